// >>> src/pss_pkg.sv
// Package: constants and types for the program sequencer and stack.
// Assumes one 40 MHz system clock and a synchronous active-high reset.
package pss_pkg;

  localparam int PC_W       = 13;
  localparam int PCH_W      = 5;
  localparam int PCL_W      = 8;
  localparam int STACK_LVLS = 8;
  localparam int SP_W       = 3;
  localparam int CNT_W      = 4;

  localparam logic [PC_W-1:0] PC_RESET   = 13'h0000;
  localparam logic [SP_W-1:0] SP_RESET   = 3'h0;
  localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;

  // Register byte addresses (AHB-Lite)
  localparam logic [7:0] ADDR_PCL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_PCFULL = 8'h08;

  // Status register fields
  localparam int ST_FULL_BIT  = 0;
  localparam int ST_EMPTY_BIT = 1;
  localparam int ST_OVF_BIT   = 2;
  localparam int ST_HOLD_BIT  = 3;
  localparam int ST_PH_LSB    = 4;
  localparam int ST_DEPTH_LSB = 8;

  typedef enum logic [1:0]
  {
    PSS_FETCH,
    PSS_DEC,
    PSS_EXEC,
    PSS_WB
  } pss_phase_t;

  typedef enum logic [2:0]
  {
    PSS_OP_NEXT,
    PSS_OP_JUMP,
    PSS_OP_CALL,
    PSS_OP_RET,
    PSS_OP_INTERRUPT_RETURN,
    PSS_OP_SKIP
  } pss_op_t;

endpackage

// >>> src/pss_stack_if.sv
// Interface: push/pop channel between sequencer and stack memory.
// Assumes both ends run on the same system clock.
interface pss_stack_if;
  import pss_pkg::*;

  logic              push;
  logic              pop;
  logic [PC_W-1:0]   push_data;
  logic [PC_W-1:0]   top_data;
  logic              full;
  logic              empty;
  logic              overflow;
  logic [SP_W:0]     depth;

  modport seq
  (
    output push, pop, push_data,
    input  top_data, full, empty, overflow, depth
  );
  modport stk
  (
    input  push, pop, push_data,
    output top_data, full, empty, overflow, depth
  );
endinterface

// >>> src/pss_stack.sv
// Return-address stack memory, eight entries, circular.
// Assumes at most one of push and pop in a cycle.
module pss_stack
  import pss_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  pss_stack_if.stk  stk
);

  logic [PC_W-1:0] mem [STACK_LVLS];
  logic [SP_W-1:0] wr_ptr;
  logic [SP_W:0]   count;
  logic [SP_W-1:0] top_ptr;
  logic            ovf;

  assign top_ptr      = wr_ptr - 3'h1;
  assign stk.full     = (count == 4'(STACK_LVLS));
  assign stk.empty    = (count == 4'h0);
  assign stk.depth    = count;
  assign stk.overflow = ovf;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // RL15: oldest lost
  // Circular writes overwrite the oldest slot when full.
  always_ff @(posedge clk_sys)
  begin
    if (stk.push)
    begin
      mem[wr_ptr] <= stk.push_data;
    end
  end

  // RL12: pointer at top
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wr_ptr <= SP_RESET;
    end
    else if (stk.push)
    begin
      wr_ptr <= wr_ptr + 3'h1;
    end
    // RL17: wraps when empty
    else if (stk.pop)
    begin
      wr_ptr <= top_ptr;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      count <= 4'h0;
    end
    // RL14: call still pushes
    else if (stk.push && !stk.full)
    begin
      count <= count + 4'h1;
    end
    else if (stk.pop && !stk.empty)
    begin
      count <= count - 4'h1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ovf <= 1'b0;
    end
    else if (stk.push && stk.full)
    begin
      ovf <= 1'b1;
    end
  end

  // Registered read of top entry
  // RL11: pop source
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      stk.top_data <= PC_RESET;
    end
    else if (stk.push)
    begin
      stk.top_data <= stk.push_data;
    end
    else
    begin
      stk.top_data <= mem[top_ptr];
    end
  end

endmodule

// >>> src/pss_sequencer.sv
// Program sequencer: phase generator, PC, pipeline flush, stack control.
// Assumes a decoder presents op and target during the writeback phase (PSS_WB)
// and program memory returns instruction words one cycle after address.
//
// Overview of operation
// RL1: System clock split into four phases; four phases make one cycle.
// RL2: PC advances at fetch_phase start; new instruction fetched then.
// RL3: Fetch of next overlaps execution of current instruction.
// RL4: Jumps and calls take two cycles; prefetched word is flushed.
// RL5: True skip discards prefetched word and runs a dummy cycle.
// RL6: PC increments per instruction unless jump, call, interrupt, reset.
// RL7: PC is 13 bits; only the low byte is software visible. The code also returns the full 13-bit PC on reads of ADDR_PCFULL.
// RL8: Low byte write jumps within 256-word page with dummy prefetch.
// RL9: Eight-level stack of PC values, invisible to software. The code reports its depth, full, empty and overflow in ADDR_STATUS.
// RL10: Call or interrupt acknowledge pushes the current PC.
// RL11: Subroutine or interrupt return pops top entry into PC.
// RL12: Reset points the stack pointer at the empty top.
// RL13: Full stack holds interrupt pending until a return frees a level.
// RL14: Call on a full stack still executes and overflows.
// RL15: Overflow loses the oldest entry, keeps newer ones.
// RL16: Reset loads PC with zero.
// RL17: Return on empty stack wraps pointer, value unspecified, no hang.
//
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
module pss_sequencer
  import pss_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Program memory
  output logic      [pss_pkg::PC_W-1:0] pm_addr,
  output logic                       pm_req,
  input  wire logic [15:0]           pm_data,
  // Decoder
  output logic      [15:0]           instr,
  output logic                       instr_valid,
  output logic      [1:0]            phase,
  input  wire pss_pkg::pss_op_t      dec_op,
  input  wire logic [pss_pkg::PC_W-1:0] dec_target,
  input  wire logic                  skip_true,
  // Interrupt controller
  input  wire logic                  int_req,
  input  wire logic [pss_pkg::PC_W-1:0] int_vector,
  output logic                       int_ack
);
  import pss_pkg::*;

  pss_stack_if stk_bus ();

  pss_stack u_stack
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .stk     (stk_bus.stk)
  );

  pss_phase_t      ph;
  logic [PC_W-1:0] pc;
  logic            flush;
  logic            ex_valid;
  logic            pcl_wr;
  logic [PCL_W-1:0] pcl_wdata;
  logic            take_int;
  logic            redirect;
  logic [PC_W-1:0] next_pc;

  // ---------------------------------------------------------------
  // Phase generator
  // ---------------------------------------------------------------
  // RL1: four-phase cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ph <= PSS_FETCH;
    end
    else
    begin
      unique case (ph)
        PSS_FETCH: ph <= PSS_DEC;
        PSS_DEC:   ph <= PSS_EXEC;
        PSS_EXEC:  ph <= PSS_WB;
        PSS_WB:    ph <= PSS_FETCH;
      endcase
    end
  end

  assign phase = ph;

  // ---------------------------------------------------------------
  // Redirect decisions, resolved in last phase
  // ---------------------------------------------------------------
  function automatic logic is_branch(input pss_op_t op);
    return (op == PSS_OP_JUMP) || (op == PSS_OP_CALL) ||
           (op == PSS_OP_RET)  || (op == PSS_OP_INTERRUPT_RETURN);
  endfunction

  // RL13: held while full
  // Interrupts only between real instructions, never mid-flush.
  assign take_int = int_req && !stk_bus.full && ex_valid &&
                    !is_branch(dec_op) && !pcl_wr;

  assign redirect = ex_valid &&
                    (is_branch(dec_op) || take_int || pcl_wr);

  always_comb
  begin
    next_pc = pc + 13'h0001;
    if (ex_valid)
    begin
      // RL8: page-local jump
      if (pcl_wr)
      begin
        next_pc = {pc[PC_W-1:PCL_W], pcl_wdata};
      end
      else if (dec_op == PSS_OP_JUMP || dec_op == PSS_OP_CALL)
      begin
        next_pc = dec_target;
      end
      // RL11: pop into PC
      else if (dec_op == PSS_OP_RET || dec_op == PSS_OP_INTERRUPT_RETURN)
      begin
        next_pc = stk_bus.top_data;
      end
      else if (take_int)
      begin
        next_pc = int_vector;
      end
    end
  end

  // ---------------------------------------------------------------
  // Program counter
  // ---------------------------------------------------------------
  // RL16: reset vector
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pc <= PC_RESET;
    end
    // RL2: advance at fetch
    // RL6: increment or load
    else if (ph == PSS_WB)
    begin
      pc <= next_pc;
    end
  end

  // RL7: 13-bit address out
  assign pm_addr = pc;
  assign pm_req  = (ph == PSS_FETCH);

  // ---------------------------------------------------------------
  // Pipeline: fetch register and flush
  // ---------------------------------------------------------------
  // RL3: overlapped fetch
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      instr <= 16'h0000;
    end
    else if (ph == PSS_DEC)
    begin
      instr <= pm_data;
    end
  end

  // RL4: flush prefetch
  // RL5: skip dummy cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      flush <= 1'b1;
    end
    else if (ph == PSS_WB)
    begin
      flush <= redirect || (ex_valid && skip_true);
    end
  end

  // Fetched word becomes executable in the execute phase of its own cycle unless flushed.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ex_valid <= 1'b0;
    end
    else if (ph == PSS_DEC)
    begin
      ex_valid <= !flush;
    end
  end

  assign instr_valid = ex_valid;

  // ---------------------------------------------------------------
  // Stack control
  // ---------------------------------------------------------------
  // RL10: push on call/int
  // RL14: full still pushes
  assign stk_bus.push = (ph == PSS_WB) && ex_valid && !pcl_wr &&
                        ((dec_op == PSS_OP_CALL) || take_int);
  assign stk_bus.push_data = pc;
  // RL17: empty pop allowed
  assign stk_bus.pop  = (ph == PSS_WB) && ex_valid && !pcl_wr &&
                        ((dec_op == PSS_OP_RET) ||
                         (dec_op == PSS_OP_INTERRUPT_RETURN));
  // RL13: ack once free
  assign int_ack = (ph == PSS_WB) && take_int;

  // ---------------------------------------------------------------
  // AHB-Lite register slave
  // ---------------------------------------------------------------
  logic       dp_wr;
  logic       dp_rd;
  logic [7:0] dp_addr;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      dp_wr   <= 1'b0;
      dp_rd   <= 1'b0;
      dp_addr <= 8'h00;
    end
    else if (hready)
    begin
      dp_wr   <= hsel && htrans[1] && hwrite;
      dp_rd   <= hsel && htrans[1] && !hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  // Software write held until the next redirect point.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pcl_wr    <= 1'b0;
      pcl_wdata <= 8'h00;
    end
    else if (dp_wr && dp_addr == ADDR_PCL)
    begin
      pcl_wr    <= 1'b1;
      pcl_wdata <= hwdata[PCL_W-1:0];
    end
    else if (ph == PSS_WB && ex_valid)
    begin
      pcl_wr <= 1'b0;
    end
  end

  // RL9: stack not mapped
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      unique case (haddr[7:0])
        ADDR_PCL:    hrdata <= {24'h000000, pc[PCL_W-1:0]};
        ADDR_STATUS: hrdata <= {20'h00000, stk_bus.depth,
                                2'b00, ph,
                                int_req && stk_bus.full,
                                stk_bus.overflow,
                                stk_bus.empty, stk_bus.full};
        ADDR_PCFULL: hrdata <= {19'h00000, pc};
        default:     hrdata <= 32'h0000_0000;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule

// >>> testbench/pss_sva.sv
// Checker: port relations of the program sequencer.
// Assumes a bind to pss_sequencer and one clock domain.
module pss_sva
  import pss_pkg::*;
(
  input wire logic                     clk_sys,
  input wire logic                     rst,
  input wire logic                     hreadyout,
  input wire logic                     hresp,
  input wire logic [pss_pkg::PC_W-1:0] pm_addr,
  input wire logic                     pm_req,
  input wire logic                     instr_valid,
  input wire logic [1:0]               phase,
  input wire pss_pkg::pss_op_t         dec_op,
  input wire logic [pss_pkg::PC_W-1:0] dec_target,
  input wire logic                     skip_true,
  input wire logic                     int_req,
  input wire logic                     int_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---
  // Properties
  // ---
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  logic x3;
  assign x3 = phase == 2'h3 && instr_valid;

  a_phase_walk: assert property (
    !rst |=> phase == 2'($past(phase) + 2'h1)) else $error("phase skip");
  a_fetch_req: assert property (
    pm_req == (phase == 2'h0)) else $error("fetch outside phase 0");
  a_pc_hold: assert property (
    phase != 2'h3 |=> $stable(pm_addr)) else $error("pc moved early");
  a_pc_incr: assert property (
    x3 && dec_op == PSS_OP_NEXT && !int_ack
    |=> pm_addr == $past(pm_addr) + 13'h0001) else $error("no increment");
  a_overlap_run: assert property (
    x3 && dec_op == PSS_OP_NEXT && !int_ack |=> ##2 instr_valid)
    else $error("needless flush");
  a_jump_load: assert property (
    x3 && dec_op == PSS_OP_JUMP |=> pm_addr == $past(dec_target))
    else $error("jump target");
  a_branch_flush: assert property (
    x3 && dec_op inside {PSS_OP_JUMP, PSS_OP_CALL, PSS_OP_RET, PSS_OP_INTERRUPT_RETURN}
    |=> ##2 !instr_valid) else $error("no flush");
  a_skip_flush: assert property (
    x3 && dec_op == PSS_OP_SKIP && skip_true |=> ##2 !instr_valid)
    else $error("skip no flush");
  a_ack_place: assert property (
    int_ack |-> x3 && int_req ##1 !int_ack) else $error("bad ack");
  a_reset_pc: assert property (
    $fell(rst) |-> pm_addr == 13'h0000 && phase == 2'h0)
    else $error("reset pc");
  a_bus_okay: assert property (
    !hresp && hreadyout) else $error("bus response");
  c_call: cover property (x3 && dec_op == PSS_OP_CALL);
  c_ack: cover property (int_ack);
  c_skip: cover property (x3 && dec_op == PSS_OP_SKIP && skip_true);
endmodule

// >>> testbench/pss_pmem.sv
// Program memory model, one cycle from address to word.
// Assumes pm_addr holds while pm_req is high.
module pss_pmem
  import pss_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic [pss_pkg::PC_W-1:0] pm_addr,
  input  wire logic                     pm_req,
  output logic      [15:0]              pm_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Word is the inverted address; idle bus toggles, never holds
  // word fetched in fetch_phase
  always_ff @(posedge clk_sys)
  begin
    if (pm_req)
      pm_data <= {3'h7, ~pm_addr};
    else
      pm_data <= ~pm_data;
  end
endmodule

// >>> testbench/pss_sequencer_tb.sv
// Testbench: sequencer, memory model, AHB-Lite master tasks.
// Assumes the design answers the bus with zero wait.
module pss_sequencer_tb
  import pss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        skip_true = 1'b0;
  logic        int_req = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic        hready, hreadyout, hresp, pm_req, instr_valid, int_ack, iv;
  logic [1:0]  phase;
  logic [15:0] pm_data, instr, ins;
  logic [12:0] pm_addr, cur, vcur;
  logic [12:0] dec_target = 13'h0000;
  logic [12:0] q[$];
  pss_op_t     dec_op = PSS_OP_NEXT;
  int          bad_count = 0;
  int          n_compared = 0;
  int          acks = 0;

  always #12.5 clk_sys = ~clk_sys;
  assign hready = hreadyout;
  // Counted mid-cycle, so a check at the next rising edge never races it
  always @(negedge clk_sys)
    if (int_ack === 1'b1)
      acks++;

  pss_sequencer dut
  (
    .clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .pm_addr, .pm_req, .pm_data,
    .instr, .instr_valid, .phase, .dec_op, .dec_target, .skip_true,
    .int_req, .int_vector(13'h0A00), .int_ack
  );
  pss_pmem pmem (.clk_sys, .pm_addr, .pm_req, .pm_data);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic st(input logic [3:0] d, input logic [3:0] f);
    ahb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd & 32'hF0F, (32'(d) << ST_DEPTH_LSB) | 32'(f));
  endtask

  task automatic sync;
    do
    begin
      @(posedge clk_sys);
      #1;
    end
    while (phase !== 2'h3);
    @(posedge clk_sys);
  endtask

  // One instruction cycle; pc and decode view are kept
  task automatic op(input pss_op_t o, input logic [12:0] t, input logic s);
    dec_op <= o;
    dec_target <= t;
    skip_true <= s;
    @(posedge clk_sys);
    cur = pm_addr;
    repeat (2) @(posedge clk_sys);
    iv = instr_valid;
    ins = instr;
    @(posedge clk_sys);
  endtask

  task automatic call(input logic [12:0] t);
    op(PSS_OP_CALL, t, 1'b0);
    q.push_back(cur);
    if (q.size() > 8)
      void'(q.pop_front());
    op(PSS_OP_NEXT, 13'h0, 1'b0);
    chk(32'(cur), 32'(t));
  endtask

  task automatic ret(input pss_op_t o);
    op(o, 13'h0, 1'b0);
    op(PSS_OP_NEXT, 13'h0, 1'b0);
    chk(32'(cur), 32'(q.pop_back()));
  endtask

  task automatic t_reset;
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk(32'(pm_addr), 32'h0);
    ahb(1'b1, ADDR_STATUS, 32'hFFFF);
    st(4'h0, 4'h2);
    $display("reset test done");
  endtask

  task automatic t_flow;
    sync;
    op(PSS_OP_NEXT, 13'h0, 1'b0);
    chk(32'(ins), {19'h0, 3'h7, ~cur});
    chk(32'(iv), 32'h1);
    op(PSS_OP_JUMP, 13'h1234, 1'b0);
    op(PSS_OP_NEXT, 13'h0, 1'b0);
    chk(32'(cur), 32'h1234);
    chk(32'(iv), 32'h0);
    op(PSS_OP_SKIP, 13'h0, 1'b0);
    chk(32'(cur), 32'h1235);
    // Skip held false so the low byte write lands on a valid cycle
    ahb(1'b1, 8'h00, 32'h1A5);
    // PC takes the written low byte at this edge; the dummy cycle follows it
    @(posedge clk_sys);
    op(PSS_OP_NEXT, 13'h0, 1'b0);
    chk(32'(cur), 32'h12A5);
    chk(32'(iv), 32'h0);
    op(PSS_OP_SKIP, 13'h0, 1'b1);
    op(PSS_OP_NEXT, 13'h0, 1'b0);
    chk(32'(iv), 32'h0);
    ahb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0000_00A8);
    $display("flow test done");
  endtask

  task automatic t_stack;
    sync;
    for (int i = 0; i < 8; i++)
      call(13'h0100 + 13'(i));
    st(4'h8, 4'h1);
    int_req <= 1'b1;
    sync;
    repeat (2) op(PSS_OP_NEXT, 13'h0, 1'b0);
    chk(acks, 0);
    ret(PSS_OP_RET);
    op(PSS_OP_NEXT, 13'h0, 1'b0);
    vcur = cur;
    chk(acks, 1);
    int_req <= 1'b0;
    op(PSS_OP_NEXT, 13'h0, 1'b0);
    chk(32'(cur), 32'h0A00);
    q.push_back(vcur);
    ret(PSS_OP_INTERRUPT_RETURN);
    call(13'h0300);
    call(13'h0301);
    st(4'h8, 4'h5);
    sync;
    repeat (8) ret(PSS_OP_RET);
    op(PSS_OP_RET, 13'h0, 1'b0);
    repeat (2) op(PSS_OP_NEXT, 13'h0, 1'b0);
    chk(32'(iv), 32'h1);
    $display("stack test done");
  endtask

  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    t_reset;
    t_flow;
    t_stack;
    t_reset;
    final_report;
  end

  initial
  begin
    #100us;
    bad_count++;
    final_report;
  end
endmodule

bind pss_sequencer pss_sva sva
(
  .clk_sys, .rst, .hreadyout, .hresp, .pm_addr, .pm_req, .instr_valid,
  .phase, .dec_op, .dec_target, .skip_true, .int_req, .int_ack
);
